// ==== core/pot_cmd_consts.svh ====
// Constants of the single-wire potentiometer command unit
`ifndef POT_CMD_CONSTS_SVH
`define POT_CMD_CONSTS_SVH

// ****************************************
// Function command and release codes
// ****************************************
`define CMD_READ_POS      8'hF0
`define CMD_WRITE_POS     8'h0F
`define CMD_READ_CTRL     8'hAA
`define CMD_WRITE_CTRL    8'h55
`define CMD_INCREMENT     8'hC3
`define CMD_DECREMENT     8'h99
`define RELEASE_CODE      8'h96

// ****************************************
// Register values and fields
// ****************************************
`define FEATURE_VALUE     8'hF3
`define CTRL_RESET        8'h0C
`define CTRL_VALID_OFF    8'h0C
`define CTRL_VALID_ON     8'h4C
`define CTRL_WSEL_LSB     0
`define CTRL_WSEL_MSB     1
`define CTRL_WSEL_N_LSB   2
`define CTRL_WSEL_N_MSB   3
`define CTRL_PUMP_BIT     6
`define WIPER_RESET       8'h00
`define WIPER_MAX         8'hFF
`define WIPER_MIN         8'h00
`define INVALID_ECHO      8'hFF

// ****************************************
// Identification CRC
// ****************************************
`define CRC_POLY_REFLECT  8'h8C
`define CRC_INIT          8'h00

`endif

// ==== core/pot_cmd_pkg.sv ====
// Types of the single-wire potentiometer command unit
package pot_cmd_pkg;

  typedef enum logic [3:0] {
    ST_WAIT_SEL,
    ST_CMD,
    ST_TX,
    ST_DATA,
    ST_RELEASE,
    ST_FILL,
    ST_IGNORE
  } state_type;

  typedef enum logic [2:0] {
    FN_READ_POS,
    FN_WRITE_POS,
    FN_READ_CTRL,
    FN_WRITE_CTRL,
    FN_INCREMENT,
    FN_DECREMENT
  } func_type;

  // Bit-slot events from the link layer, all one-cycle pulses except wr_bit
  typedef struct packed {
    logic bus_reset;
    logic select_done;
    logic wr_valid;
    logic wr_bit;
    logic rd_req;
  } link_in_type;

  typedef struct packed {
    logic rd_valid;
    logic rd_bit;
  } link_out_type;

  typedef struct packed {
    state_type   state;
    func_type    func;
    logic        phase;
    logic [2:0]  cnt;
    logic [7:0]  shift;
    logic [7:0]  tx;
    logic [7:0]  rx_val;
    logic        fill;
    logic [7:0]  wiper;
    logic [7:0]  ctrl;
    logic        rd_valid;
    logic        rd_bit;
    logic [63:0] rom_id;
  } core_state_type;

endpackage

// ==== core/id_crc8.sv ====
// Serial identification CRC over a data word, shifted least significant bit first
`timescale 1ns/10ps
`include "pot_cmd_consts.svh"

module id_crc8 #(
  parameter int WIDTH = 56
) (
  input  wire logic [WIDTH-1:0] data,   // Bits to shift in, bit 0 first
  output logic      [7:0]       crc     // Generator contents after the last bit
);

  always_comb begin
    logic [7:0] acc;
    logic       fb;
    acc = `CRC_INIT;
    fb  = 1'b0;
    for (int i = 0; i < WIDTH; i++) begin
      fb  = acc[0] ^ data[i];
      acc = {1'b0, acc[7:1]};
      if (fb) begin
        acc = acc ^ `CRC_POLY_REFLECT;
      end
    end
    crc = acc;
  end

endmodule // id_crc8

// ==== core/pot_cmd_unit.sv ====
// Function command layer and identification value of a single-wire digital potentiometer
`timescale 1ns/10ps
`include "pot_cmd_consts.svh"

// Contract
// - Hold 64-bit identity: 8-bit family, 48-bit serial, 8-bit CRC over 56 bits.
// - CRC starts at zero, family shifted in LSB first, then serial.
// - Shifting the stored CRC through the generator leaves all zeros.
// - A function is one command byte then data bytes, only after selection.
// - All function bits travel least significant bit first.
// - Wiper commands act on the wiper named by the wiper-select field.
// - Read position returns control byte then wiper position byte.
// - After the read position bytes, further reads return zeros until reset.
// - Write position receives a byte and echoes it in the next read.
// - Correct release byte commits wiper position; later reads give zeros.
// - Wrong release byte keeps wiper; later reads give ones.
// - Read control returns feature byte, control byte, then zeros.
// - Write control receives a byte and echoes it next.
// - Invalid control value echoes as all ones.
// - Release commits control, zeros after; wrong release keeps it, ones after.
// - Increment raises wiper one step, returns it, saturates at maximum.
// - After increment or decrement, accept a new function command directly.
// - Decrement lowers wiper one step, returns it, saturates at zero.
// - Control holds wiper select 1:0, complement 3:2, pump bit 6; resets 0Ch.
// - Only 0Ch and 4Ch are accepted control values.
// - Feature register reads as fixed F3h.
module pot_cmd_unit #(
  parameter logic [7:0]  FAMILY_CODE = 8'h5A,               // Arbitrary value
  parameter logic [47:0] SERIAL_NUM  = 48'h0000_0000_0001   // Arbitrary value
) (
  input  wire logic                       sys_clk,        // 100 MHz clock
  input  wire logic                       sys_rst,        // Synchronous reset, active high
  input  wire logic                       clk_en,         // Freezes all state while low
  input  wire pot_cmd_pkg::link_in_type   link_in,        // Bit-slot events from the link layer
  output      pot_cmd_pkg::link_out_type  link_out,       // Answer to a read slot
  output      logic [7:0]                 wiper_pos,      // Committed wiper position
  output      logic [7:0]                 ctrl_reg,       // Committed control register
  output      logic                       charge_pump_on, // Charge pump enable
  output      logic [1:0]                 wiper_select,   // Addressed wiper number
  output      logic [63:0]                rom_id,         // Identification value, bit 0 first on the wire
  output      logic                       rom_crc_ok,     // Identification value checks to zero
  output      logic                       func_active     // A function command is in progress
);

  // ****************************************
  // Identification value
  // ****************************************
  logic [7:0]  id_crc;
  logic [7:0]  id_residue;
  logic [63:0] id_value;

  id_crc8 #(.WIDTH(56)) u_crc_gen (
    .data ({SERIAL_NUM, FAMILY_CODE}),
    .crc  (id_crc)
  );

  assign id_value = {id_crc, SERIAL_NUM, FAMILY_CODE};

  id_crc8 #(.WIDTH(64)) u_crc_chk (
    .data (id_value),
    .crc  (id_residue)
  );

  // ****************************************
  // State
  // ****************************************
  pot_cmd_pkg::core_state_type q;
  pot_cmd_pkg::core_state_type d;

  logic [7:0] rx_byte;
  logic       byte_in;
  logic       byte_out;
  logic [1:0] sel_field;
  logic [1:0] sel_inv;
  logic       addressed;
  logic       ctrl_ok;

  // ****************************************
  // Byte framing
  // ****************************************
  // LSB first: each new bit enters at the top and moves down
  assign rx_byte  = {link_in.wr_bit, q.shift[7:1]};
  assign byte_in  = link_in.wr_valid && (q.cnt == 3'h7);
  assign byte_out = link_in.rd_req && (q.cnt == 3'h7);

  // ****************************************
  // Control decode
  // ****************************************
  assign sel_field = q.ctrl[`CTRL_WSEL_MSB:`CTRL_WSEL_LSB];
  assign sel_inv   = q.ctrl[`CTRL_WSEL_N_MSB:`CTRL_WSEL_N_LSB];

  // Only wiper zero exists; wiper commands act only when the field names it
  assign addressed = (sel_field == 2'h0) && (sel_inv == 2'h3);
  assign ctrl_ok   = (q.rx_val == `CTRL_VALID_OFF) || (q.rx_val == `CTRL_VALID_ON);

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    d          = q;
    d.rd_valid = 1'b0;
    d.rom_id   = id_value;

    // Read slots: a released bus reads as one unless a byte or fill is due
    if (link_in.rd_req) begin
      d.rd_valid = 1'b1;
      if (q.state == pot_cmd_pkg::ST_TX) begin
        d.rd_bit = q.tx[0];
        d.tx     = {1'b0, q.tx[7:1]};
      end else if (q.state == pot_cmd_pkg::ST_FILL) begin
        d.rd_bit = q.fill;
      end else begin
        d.rd_bit = 1'b1;
      end
    end

    case (q.state)
      pot_cmd_pkg::ST_WAIT_SEL: begin
        // Select pulses count only here, so a stray one mid-function is harmless
        if (link_in.select_done) begin
          d.state = pot_cmd_pkg::ST_CMD;
          d.cnt   = 3'h0;
        end
      end
      pot_cmd_pkg::ST_CMD: begin
        if (link_in.wr_valid) begin
          d.shift = rx_byte;
          d.cnt   = q.cnt + 3'h1;
        end
        if (byte_in) begin
          d.phase = 1'b0;
          if (rx_byte == `CMD_READ_POS) begin
            d.func  = pot_cmd_pkg::FN_READ_POS;
            d.tx    = q.ctrl;
            d.state = pot_cmd_pkg::ST_TX;
          end else if (rx_byte == `CMD_READ_CTRL) begin
            d.func  = pot_cmd_pkg::FN_READ_CTRL;
            d.tx    = `FEATURE_VALUE;
            d.state = pot_cmd_pkg::ST_TX;
          end else if (rx_byte == `CMD_WRITE_POS) begin
            d.func  = pot_cmd_pkg::FN_WRITE_POS;
            d.state = pot_cmd_pkg::ST_DATA;
          end else if (rx_byte == `CMD_WRITE_CTRL) begin
            d.func  = pot_cmd_pkg::FN_WRITE_CTRL;
            d.state = pot_cmd_pkg::ST_DATA;
          end else if (rx_byte == `CMD_INCREMENT) begin
            d.func  = pot_cmd_pkg::FN_INCREMENT;
            // The step is taken at command receipt; the read-back only reports it
            if (addressed && (q.wiper != `WIPER_MAX)) begin
              d.wiper = q.wiper + 8'h01;
            end
            d.tx    = d.wiper;
            d.state = pot_cmd_pkg::ST_TX;
          end else if (rx_byte == `CMD_DECREMENT) begin
            d.func  = pot_cmd_pkg::FN_DECREMENT;
            if (addressed && (q.wiper != `WIPER_MIN)) begin
              d.wiper = q.wiper - 8'h01;
            end
            d.tx    = d.wiper;
            d.state = pot_cmd_pkg::ST_TX;
          end else begin
            d.state = pot_cmd_pkg::ST_IGNORE;
          end
        end
      end
      pot_cmd_pkg::ST_TX: begin
        // Writes are ignored while a byte goes out
        if (link_in.rd_req) begin
          d.cnt = q.cnt + 3'h1;
        end
        if (byte_out) begin
          case (q.func)
            pot_cmd_pkg::FN_READ_POS: begin
              if (!q.phase) begin
                d.tx    = q.wiper;
                d.phase = 1'b1;
              end else begin
                d.fill  = 1'b0;
                d.state = pot_cmd_pkg::ST_FILL;
              end
            end
            pot_cmd_pkg::FN_READ_CTRL: begin
              if (!q.phase) begin
                d.tx    = q.ctrl;
                d.phase = 1'b1;
              end else begin
                d.fill  = 1'b0;
                d.state = pot_cmd_pkg::ST_FILL;
              end
            end
            pot_cmd_pkg::FN_WRITE_POS,
            pot_cmd_pkg::FN_WRITE_CTRL: begin
              d.state = pot_cmd_pkg::ST_RELEASE;
            end
            default: begin
              d.state = pot_cmd_pkg::ST_CMD;
            end
          endcase
        end
      end
      pot_cmd_pkg::ST_DATA: begin
        if (link_in.wr_valid) begin
          d.shift = rx_byte;
          d.cnt   = q.cnt + 3'h1;
        end
        if (byte_in) begin
          d.rx_val = rx_byte;
          d.state  = pot_cmd_pkg::ST_TX;
          if ((q.func == pot_cmd_pkg::FN_WRITE_CTRL) &&
              (rx_byte != `CTRL_VALID_OFF) && (rx_byte != `CTRL_VALID_ON)) begin
            d.tx = `INVALID_ECHO;
          end else begin
            d.tx = rx_byte;
          end
        end
      end
      pot_cmd_pkg::ST_RELEASE: begin
        if (link_in.wr_valid) begin
          d.shift = rx_byte;
          d.cnt   = q.cnt + 3'h1;
        end
        if (byte_in) begin
          d.state = pot_cmd_pkg::ST_FILL;
          // Ones unless a valid value is committed, so a refused value reads as ones
          d.fill  = 1'b1;
          if (rx_byte == `RELEASE_CODE) begin
            if (q.func == pot_cmd_pkg::FN_WRITE_POS) begin
              d.fill = 1'b0;
              if (addressed) begin
                d.wiper = q.rx_val;
              end
            end else if (ctrl_ok) begin
              d.ctrl = q.rx_val;
              d.fill = 1'b0;
            end
          end
        end
      end
      pot_cmd_pkg::ST_FILL: begin
        // The fill bit answers every read until a bus reset
      end
      pot_cmd_pkg::ST_IGNORE: begin
        // Bus stays released and writes are dropped until a bus reset
      end
      default: begin
        // Unused encodings park quietly instead of decoding stray traffic
        d.state = pot_cmd_pkg::ST_IGNORE;
      end
    endcase

    // Bus reset outranks any select or write slot in the same cycle; a read slot is still answered. A commit or a step taken
    // from this cycle's last bit is undone, so a function cut on its last bit changes nothing
    if (link_in.bus_reset) begin
      d.state = pot_cmd_pkg::ST_WAIT_SEL;
      d.cnt   = 3'h0;
      d.phase = 1'b0;
      d.fill  = 1'b1;
      d.wiper = q.wiper;
      d.ctrl  = q.ctrl;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q.state    <= pot_cmd_pkg::ST_WAIT_SEL;
      q.func     <= pot_cmd_pkg::FN_READ_POS;
      q.phase    <= 1'b0;
      q.cnt      <= 3'h0;
      q.shift    <= 8'h00;
      q.tx       <= 8'h00;
      q.rx_val   <= 8'h00;
      q.fill     <= 1'b1;
      q.wiper    <= `WIPER_RESET;
      q.ctrl     <= `CTRL_RESET;
      q.rd_valid <= 1'b0;
      q.rd_bit   <= 1'b1;
      q.rom_id   <= 64'h0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link_out.rd_valid = q.rd_valid;
  assign link_out.rd_bit   = q.rd_bit;
  assign wiper_pos         = q.wiper;
  assign ctrl_reg          = q.ctrl;
  assign charge_pump_on    = q.ctrl[`CTRL_PUMP_BIT];
  assign wiper_select      = q.ctrl[`CTRL_WSEL_MSB:`CTRL_WSEL_LSB];
  assign rom_id            = q.rom_id;
  // Built from constants only; it stays high for any family or serial parameter
  assign rom_crc_ok        = (id_residue == 8'h00);
  assign func_active       = (q.state != pot_cmd_pkg::ST_WAIT_SEL);

endmodule // pot_cmd_unit

// ==== test/pot_cmd_unit_chk.sv ====
// Concurrent checks on the ports of the potentiometer command unit
`timescale 1ns/10ps
`include "pot_cmd_consts.svh"

module pot_cmd_unit_chk (
  input wire logic                      sys_clk,        // Clock
  input wire logic                      sys_rst,        // Synchronous reset
  input wire logic                      clk_en,         // Clock enable
  input wire pot_cmd_pkg::link_in_type  link_in,        // Bit-slot events
  input wire pot_cmd_pkg::link_out_type link_out,       // Read answers
  input wire logic [7:0]                wiper_pos,      // Committed wiper
  input wire logic [7:0]                ctrl_reg,       // Control register
  input wire logic                      charge_pump_on, // Pump enable
  input wire logic [1:0]                wiper_select,   // Addressed wiper
  input wire logic [63:0]               rom_id,         // Identification value
  input wire logic                      rom_crc_ok,     // Identification check
  input wire logic                      func_active     // Function in progress
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // Assertions
  // ****************************************
  AST_RD_ANSWER: assert property (clk_en && link_in.rd_req |=> link_out.rd_valid)
    else $error("read slot not answered");
  AST_RD_CAUSE: assert property ($past(clk_en) |-> link_out.rd_valid == $past(link_in.rd_req))
    else $error("answer without read slot");
  AST_IDLE_QUIET: assert property (!func_active |=> $stable(wiper_pos) && $stable(ctrl_reg))
    else $error("state changed outside a function");
  AST_SELECT: assert property (clk_en && link_in.select_done && !link_in.bus_reset && !func_active |=>
    func_active)
    else $error("selection did not open a function");
  AST_ABORT: assert property (clk_en && link_in.bus_reset |=> !func_active)
    else $error("bus reset did not end the function");
  AST_ABORT_KEEPS: assert property (clk_en && link_in.bus_reset |=>
    $stable(wiper_pos) && $stable(ctrl_reg))
    else $error("bus reset committed a pending value");
  AST_PUMP_MAP: assert property (charge_pump_on == ctrl_reg[`CTRL_PUMP_BIT])
    else $error("pump output differs from control bit");
  AST_WSEL_MAP: assert property (wiper_select == ctrl_reg[1:0] && ctrl_reg[3:2] == ~ctrl_reg[1:0])
    else $error("wiper select field inconsistent");
  AST_CTRL_VALID: assert property (ctrl_reg inside {`CTRL_VALID_OFF, `CTRL_VALID_ON})
    else $error("control register holds an invalid value");
  AST_CRC_OK: assert property (rom_crc_ok)
    else $error("identification check failed");
  COV_PUMP_ON: cover property ($rose(charge_pump_on));
  COV_WIPER_MAX: cover property (wiper_pos == `WIPER_MAX);
  COV_ABORT: cover property (func_active && link_in.bus_reset);
endmodule // pot_cmd_unit_chk

// ==== test/pot_bus_master.sv ====
// Bus master model issuing bit-slot events to the command unit
`timescale 1ns/10ps

module pot_bus_master (
  input  wire logic                      sys_clk,  // Clock
  output pot_cmd_pkg::link_in_type       link_in,  // Bit-slot events
  input  wire pot_cmd_pkg::link_out_type link_out  // Read answers
);
  initial link_in = '0;
  task automatic bus_rst();
    @(posedge sys_clk);
    link_in.bus_reset <= 1'b1;
    @(posedge sys_clk);
    link_in.bus_reset <= 1'b0;
  endtask
  task automatic select();
    @(posedge sys_clk);
    link_in.select_done <= 1'b1;
    @(posedge sys_clk);
    link_in.select_done <= 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      link_in.wr_valid <= 1'b1;
      link_in.wr_bit   <= v[i];
      @(posedge sys_clk);
      link_in.wr_valid <= 1'b0;
      // Stale bit inverted so a late sample cannot match by luck
      link_in.wr_bit   <= ~v[i];
    end
  endtask
  // Last bit of the byte lands together with a bus reset
  task automatic wr_byte_cut(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      link_in.wr_valid  <= 1'b1;
      link_in.wr_bit    <= v[i];
      link_in.bus_reset <= (i == 7);
      @(posedge sys_clk);
      link_in.wr_valid  <= 1'b0;
      link_in.bus_reset <= 1'b0;
    end
  endtask
  task automatic rd_byte(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      link_in.rd_req <= 1'b1;
      @(posedge sys_clk);
      link_in.rd_req <= 1'b0;
      #1;
      v[i] = link_out.rd_valid ? link_out.rd_bit : 1'bx;
    end
  endtask
endmodule // pot_bus_master

// ==== test/test_single_wire_pot_command_unit.sv ====
// Self-checking bench of the potentiometer command unit
`timescale 1ns/10ps
`include "pot_cmd_consts.svh"

module test_single_wire_pot_command_unit;
  localparam logic [7:0]  FAMILY = 8'h3B;             // Arbitrary value
  localparam logic [47:0] SERIAL = 48'hA1B2_C3D4_E5F6; // Arbitrary value
  logic                      sys_clk = 1'b0;
  logic                      sys_rst = 1'b1;
  logic                      clk_en = 1'b1;
  pot_cmd_pkg::link_in_type  link_in;
  pot_cmd_pkg::link_out_type link_out;
  logic [7:0]                wiper_pos;
  logic [7:0]                ctrl_reg;
  logic                      charge_pump_on;
  logic [1:0]                wiper_select;
  logic [63:0]               rom_id;
  logic                      rom_crc_ok;
  logic                      func_active;
  logic [15:0]               steps [4] = '{16'hC302, 16'h9901, 16'h9900, 16'h9900};
  int                        errors = 0;
  int                        total_checks = 0;

  always #5 sys_clk = ~sys_clk;

  pot_cmd_unit #(.FAMILY_CODE(FAMILY), .SERIAL_NUM(SERIAL)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .link_in(link_in), .link_out(link_out), .wiper_pos(wiper_pos), .ctrl_reg(ctrl_reg),
    .charge_pump_on(charge_pump_on), .wiper_select(wiper_select), .rom_id(rom_id),
    .rom_crc_ok(rom_crc_ok), .func_active(func_active));
  pot_bus_master m (.sys_clk(sys_clk), .link_in(link_in), .link_out(link_out));

  // ****************************************
  // Helpers
  // ****************************************
  // Reflected generator, bit 0 first, kept apart from the design's own
  function automatic logic [7:0] crc8(input logic [63:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    return c;
  endfunction
  task automatic check(input logic [63:0] g, e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic start(input logic [7:0] c);
    m.bus_rst();
    m.select();
    m.wr_byte(c);
  endtask
  task automatic rd(input logic [7:0] e);
    logic [7:0] g;
    m.rd_byte(g);
    check(g, e);
  endtask
  task automatic write_seq(input logic [7:0] c, v, echo, rel, fill);
    start(c);
    m.wr_byte(v);
    rd(echo);
    m.wr_byte(rel);
    rd(fill);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check(wiper_pos, `WIPER_RESET);
    check({ctrl_reg, charge_pump_on, wiper_select}, {`CTRL_RESET, 3'b000});
    check({rom_id[55:8], rom_id[7:0]}, {SERIAL, FAMILY});
    check(rom_id[63:56], crc8({8'h00, SERIAL, FAMILY}, 56));
    check({rom_crc_ok, crc8(rom_id, 64)}, 9'h100);
    start(`CMD_READ_CTRL);
    rd(`FEATURE_VALUE);
    rd(`CTRL_RESET);
    rd(8'h00);
    start(`CMD_INCREMENT);
    rd(8'h01);
    foreach (steps[i]) begin
      m.wr_byte(steps[i][15:8]);
      rd(steps[i][7:0]);
    end
    write_seq(`CMD_WRITE_POS, 8'hFF, 8'hFF, `RELEASE_CODE, 8'h00);
    check(wiper_pos, 8'hFF);
    start(`CMD_INCREMENT);
    rd(8'hFF);
    write_seq(`CMD_WRITE_POS, 8'h5A, 8'h5A, 8'h69, 8'hFF);
    check(wiper_pos, 8'hFF);
    start(`CMD_WRITE_POS);
    m.wr_byte(8'h10);
    rd(8'h10);
    m.bus_rst();
    #1;
    check({func_active, wiper_pos}, {1'b0, 8'hFF});
    write_seq(`CMD_WRITE_POS, 8'h10, 8'h10, `RELEASE_CODE, 8'h00);
    // Release code cut by a bus reset on its last bit must not commit
    start(`CMD_WRITE_POS);
    m.wr_byte(8'h33);
    rd(8'h33);
    m.wr_byte_cut(`RELEASE_CODE);
    #1;
    check({func_active, wiper_pos}, {1'b0, 8'h10});
    // Frozen clock enable: a whole increment is lost
    @(posedge sys_clk);
    clk_en <= 1'b0;
    start(`CMD_INCREMENT);
    #1;
    check({func_active, wiper_pos}, {1'b0, 8'h10});
    @(posedge sys_clk);
    clk_en <= 1'b1;
    write_seq(`CMD_WRITE_CTRL, `CTRL_VALID_ON, `CTRL_VALID_ON, `RELEASE_CODE, 8'h00);
    check({ctrl_reg, charge_pump_on}, {`CTRL_VALID_ON, 1'b1});
    start(`CMD_READ_POS);
    rd(`CTRL_VALID_ON);
    rd(8'h10);
    rd(8'h00);
    write_seq(`CMD_WRITE_CTRL, 8'h0D, `INVALID_ECHO, `RELEASE_CODE, 8'hFF);
    check(ctrl_reg, `CTRL_VALID_ON);
    write_seq(`CMD_WRITE_CTRL, `CTRL_VALID_OFF, `CTRL_VALID_OFF, 8'h69, 8'hFF);
    check(ctrl_reg, `CTRL_VALID_ON);
    start(8'h3E);
    m.wr_byte(`CMD_READ_CTRL);
    rd(8'hFF);
    start(`CMD_READ_CTRL);
    rd(`FEATURE_VALUE);
    // Reset in mid-run restores the power-up values
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check({wiper_pos, ctrl_reg, func_active}, {`WIPER_RESET, `CTRL_RESET, 1'b0});
    tally_and_finish();
  end

  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule // test_single_wire_pot_command_unit

bind pot_cmd_unit pot_cmd_unit_chk chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .link_in(link_in), .link_out(link_out), .wiper_pos(wiper_pos), .ctrl_reg(ctrl_reg),
  .charge_pump_on(charge_pump_on), .wiper_select(wiper_select), .rom_id(rom_id),
  .rom_crc_ok(rom_crc_ok), .func_active(func_active));
